// ==== src/ctl_xfer_map.vh ====
// constants for the control-transfer decode and timing block
`ifndef CTL_XFER_MAP_VH
`define CTL_XFER_MAP_VH
// opcodes
`define OP_REP_PREFIX 8'hF2
`define OP_STR_OUT_PAT 7'h37
`define OP_CALL_NEAR 8'hE8
`define OP_CALL_FAR 8'h9A
`define OP_GRP_FF 8'hFF
`define OP_JUMP_SHORT 8'hEB
`define OP_JUMP_NEAR 8'hE9
`define OP_JUMP_FAR 8'hEA
`define OP_RTN_NEAR 8'hC3
`define OP_RTN_NEAR_IMM 8'hC2
`define OP_RTN_FAR 8'hCB
`define OP_RTN_FAR_IMM 8'hCA
`define OP_JCC_HI 4'h7
`define OP_JCNTZ 8'hE3
`define OP_LOOP 8'hE2
`define OP_LOOP_Z 8'hE1
`define OP_LOOP_NZ 8'hE0
`define OP_ENTER 8'hC8
`define OP_LEAVE 8'hC9
`define OP_INT_TYPE 8'hCD
`define OP_INT_BRK 8'hCC
`define OP_OVTRAP 8'hCE
`define OP_TRAP_RTN 8'hCF
`define OP_BOUND 8'h62
// mod field value selecting a register operand
`define MOD_REG 2'h3
// clock counts, 16-bit bus then 8-bit bus
`define T_STR_OUT_BASE 8'h08
`define T_STR_OUT_PER 8'h08
`define T_CALL_NEAR_W 8'h0F
`define T_CALL_NEAR_B 8'h13
`define T_CALL_IND_REG_W 8'h0D
`define T_CALL_IND_REG_B 8'h11
`define T_CALL_IND_MEM_W 8'h13
`define T_CALL_IND_MEM_B 8'h1B
`define T_CALL_FAR_W 8'h17
`define T_CALL_FAR_B 8'h1F
`define T_CALL_FIND_W 8'h26
`define T_CALL_FIND_B 8'h36
`define T_JUMP 8'h0E
`define T_JUMP_IND_REG 8'h0B
`define T_JUMP_IND_MEM_W 8'h11
`define T_JUMP_IND_MEM_B 8'h15
`define T_JUMP_FIND_W 8'h1A
`define T_JUMP_FIND_B 8'h22
`define T_RTN_W 8'h10
`define T_RTN_B 8'h14
`define T_RTN_IMM_W 8'h12
`define T_RTN_IMM_B 8'h16
`define T_RETF_W 8'h16
`define T_RETF_B 8'h1E
`define T_RETF_IMM_W 8'h19
`define T_RETF_IMM_B 8'h21
`define T_JCC_NT 8'h04
`define T_JCC_TK 8'h0D
`define T_JCNTZ_NT 8'h05
`define T_JCNTZ_TK 8'h0F
`define T_LOOP_NT 8'h06
`define T_LOOP_TK 8'h10
`define T_ENTER0_W 8'h0F
`define T_ENTER0_B 8'h13
`define T_ENTER1_W 8'h19
`define T_ENTER1_B 8'h1D
`define T_ENTERN_W 8'h16
`define T_ENTERN_B 8'h1A
`define T_ENTER_STEP_W 8'h10
`define T_ENTER_STEP_B 8'h14
`define T_LEAVE 8'h08
`define T_INT_TYPE 8'h2F
`define T_INT_BRK 8'h2D
`define T_OVTRAP_TK 8'h30
`define T_OVTRAP_NT 8'h04
`define T_TRAP_RTN 8'h1C
`define T_BOUND_MIN 8'h21
`define T_BOUND_MAX 8'h23
`define T_WORD_XFER 8'h04
`define T_ADDR_CALC 8'h04
// operand byte layout codes
`define LAY_NONE 3'h0
`define LAY_DISP8 3'h1
`define LAY_DISP16 3'h2
`define LAY_IMM16 3'h3
`define LAY_MODRM 3'h4
`define LAY_FAR_PTR 3'h5
`define LAY_ENTER 3'h6
`define LAY_TYPE8 3'h7
`endif

// ==== src/cond_eval.v ====
// branch condition evaluation for the short conditional jumps
`timescale 1ns/1ps
module cond_eval (
   input wire [3:0] cond_i,
   input wire [4:0] flags_i,
   output reg true_o
);
   // flags_i: {overflow, sign, zero, carry, parity}
   reg base;
   // pick the even-partner test, odd code inverts it
   always @* begin
      base = 1'b0;
      case (cond_i[3:1])
         3'h0: base = flags_i[4];
         3'h1: base = flags_i[1];
         3'h2: base = flags_i[2];
         3'h3: base = flags_i[1] | flags_i[2];
         3'h4: base = flags_i[3];
         3'h5: base = flags_i[0];
         3'h6: base = flags_i[3] ^ flags_i[4];
         3'h7: base = (flags_i[3] ^ flags_i[4]) | flags_i[2];
         default: base = 1'b0;
      endcase
      true_o = base ^ cond_i[0];
   end
endmodule // cond_eval

// ==== src/enter_timer.v ====
// clock count of the procedure frame entry by nesting level
`timescale 1ns/1ps
`include "ctl_xfer_map.vh"
module enter_timer #(
   parameter BYTE_BUS = 0
) (
   input wire [7:0] level_i,
   output reg [15:0] clocks_o
);
   reg [15:0] step;
   // level 0 and 1 are fixed, deeper levels add one step per level beyond the first
   always @* begin
      step = BYTE_BUS ? {8'h00, `T_ENTER_STEP_B} : {8'h00, `T_ENTER_STEP_W};
      if (level_i == 8'h00) begin
         clocks_o = BYTE_BUS ? {8'h00, `T_ENTER0_B} : {8'h00, `T_ENTER0_W};
      end else if (level_i == 8'h01) begin
         clocks_o = BYTE_BUS ? {8'h00, `T_ENTER1_B} : {8'h00, `T_ENTER1_W};
      end else begin
         clocks_o = (BYTE_BUS ? {8'h00, `T_ENTERN_B} : {8'h00, `T_ENTERN_W})
            + step * {8'h00, level_i - 8'h01};
      end
   end
endmodule // enter_timer

// ==== src/ctl_xfer_decode.v ====
// control-transfer instruction decode and clock-count timing
`timescale 1ns/1ps
`include "ctl_xfer_map.vh"
module ctl_xfer_decode #(
   parameter BYTE_BUS = 0,
   parameter CNT_W = 16
) (
   input wire clock_i,
   input wire srst_i,
   input wire byte_valid_i,
   input wire [7:0] byte_i,
   input wire cond_taken_i,
   input wire [4:0] flags_i,
   input wire [15:0] rep_count_i,
   input wire word_op_i,
   output reg decode_valid_o,
   output reg known_o,
   output reg [7:0] opcode_o,
   output reg rep_o,
   output reg [2:0] layout_o,
   output reg [1:0] mod_o,
   output reg [2:0] rm_o,
   output reg reg_operand_o,
   output reg [15:0] operand_o,
   output reg [7:0] level_o,
   output reg conditional_o,
   output reg cond_true_o,
   output reg [CNT_W-1:0] clocks_taken_o,
   output reg [CNT_W-1:0] clocks_not_taken_o,
   output reg [CNT_W-1:0] clocks_o,
   output reg [CNT_W-1:0] clocks_max_o
);
   // byte collection states
   localparam [3:0] S_OP = 4'h1;
   localparam [3:0] S_B1 = 4'h2;
   localparam [3:0] S_B2 = 4'h4;
   localparam [3:0] S_B3 = 4'h8;

   reg [3:0] state_q;
   reg [3:0] state_d;
   reg rep_q;
   reg [7:0] op_q;
   reg [7:0] b1_q;
   reg [7:0] b2_q;
   reg [2:0] lay;
   reg [1:0] need;
   reg done;
   reg known;
   reg [7:0] op_now;
   reg [7:0] b1_now;
   reg [7:0] b2_now;
   reg [7:0] b3_now;
   reg [15:0] t_tk;
   reg [15:0] t_nt;
   reg [15:0] t_max;
   reg is_cond;
   reg is_jcc;
   wire jcc_true;
   wire [15:0] enter_clk;
   reg [15:0] rep_clk;

   // operand byte count for each layout
   function [1:0] lay_bytes;
      input [2:0] l;
      begin
         case (l)
            `LAY_DISP8: lay_bytes = 2'h1;
            `LAY_TYPE8: lay_bytes = 2'h1;
            `LAY_MODRM: lay_bytes = 2'h1;
            `LAY_DISP16: lay_bytes = 2'h2;
            `LAY_IMM16: lay_bytes = 2'h2;
            `LAY_ENTER: lay_bytes = 2'h3;
            default: lay_bytes = 2'h0;
         endcase
      end
   endfunction

   // pick the 16-bit or 8-bit bus figure
   function [15:0] bw;
      input [7:0] w16;
      input [7:0] w8;
      begin
         bw = BYTE_BUS ? {8'h00, w8} : {8'h00, w16};
      end
   endfunction

   // layout of operands after the opcode; far pointers take four bytes but
   // only the two-byte offset is captured here, the rest is left to the core
   function [2:0] op_layout;
      input [7:0] op;
      begin
         op_layout = `LAY_NONE;
         if (op[7:4] == `OP_JCC_HI)
            op_layout = `LAY_DISP8;
         else begin
            case (op)
               `OP_JUMP_SHORT, `OP_JCNTZ, `OP_LOOP, `OP_LOOP_Z, `OP_LOOP_NZ:
                  op_layout = `LAY_DISP8;
               `OP_CALL_NEAR, `OP_JUMP_NEAR: op_layout = `LAY_DISP16;
               `OP_RTN_NEAR_IMM, `OP_RTN_FAR_IMM: op_layout = `LAY_IMM16;
               `OP_CALL_FAR, `OP_JUMP_FAR: op_layout = `LAY_DISP16;
               `OP_GRP_FF, `OP_BOUND: op_layout = `LAY_MODRM;
               `OP_ENTER: op_layout = `LAY_ENTER;
               `OP_INT_TYPE: op_layout = `LAY_TYPE8;
               default: op_layout = `LAY_NONE;
            endcase
         end
      end
   endfunction

   cond_eval u_cond (
      .cond_i(op_now[3:0]),
      .flags_i(flags_i),
      .true_o(jcc_true)
   );

   enter_timer #(.BYTE_BUS(BYTE_BUS)) u_enter (
      .level_i(b3_now),
      .clocks_o(enter_clk)
   );

   // current bytes including the one arriving this cycle
   always @* begin
      op_now = (state_q == S_OP) ? byte_i : op_q;
      b1_now = (state_q == S_B1) ? byte_i : b1_q;
      b2_now = (state_q == S_B2) ? byte_i : b2_q;
      b3_now = byte_i;
      lay = op_layout(op_now);
      need = lay_bytes(lay);
   end

   // sequencer: opcode, then up to three operand bytes
   always @* begin
      state_d = state_q;
      done = 1'b0;
      if (byte_valid_i) begin
         case (state_q)
            S_OP: begin
               if (byte_i == `OP_REP_PREFIX)
                  state_d = S_OP;
               else if (need == 2'h0)
                  done = 1'b1;
               else
                  state_d = S_B1;
            end
            S_B1: begin
               if (need == 2'h1) begin
                  done = 1'b1;
                  state_d = S_OP;
               end else
                  state_d = S_B2;
            end
            S_B2: begin
               if (need == 2'h2) begin
                  done = 1'b1;
                  state_d = S_OP;
               end else
                  state_d = S_B3;
            end
            S_B3: begin
               done = 1'b1;
               state_d = S_OP;
            end
            default: state_d = S_OP;
         endcase
      end
   end

   // clock counts; listed figures assume prefetched bytes and no wait
   // states and already include effective-address time
   always @* begin
      t_tk = 16'h0000;
      t_nt = 16'h0000;
      t_max = 16'h0000;
      is_cond = 1'b0;
      is_jcc = 1'b0;
      known = 1'b1;
      rep_clk = {8'h00, `T_STR_OUT_BASE} + {8'h00, `T_STR_OUT_PER} * rep_count_i;
      if (op_now[7:4] == `OP_JCC_HI) begin
         is_cond = 1'b1;
         is_jcc = 1'b1;
         t_tk = {8'h00, `T_JCC_TK};
         t_nt = {8'h00, `T_JCC_NT};
      end else if (op_now[7:1] == `OP_STR_OUT_PAT) begin
         if (rep_q)
            t_tk = rep_clk;
         else
            known = 1'b0;
      end else begin
         case (op_now)
            `OP_CALL_NEAR: t_tk = bw(`T_CALL_NEAR_W, `T_CALL_NEAR_B);
            `OP_CALL_FAR: t_tk = bw(`T_CALL_FAR_W, `T_CALL_FAR_B);
            `OP_JUMP_SHORT, `OP_JUMP_NEAR, `OP_JUMP_FAR: t_tk = {8'h00, `T_JUMP};
            `OP_RTN_NEAR: t_tk = bw(`T_RTN_W, `T_RTN_B);
            `OP_RTN_NEAR_IMM: t_tk = bw(`T_RTN_IMM_W, `T_RTN_IMM_B);
            `OP_RTN_FAR: t_tk = bw(`T_RETF_W, `T_RETF_B);
            `OP_RTN_FAR_IMM: t_tk = bw(`T_RETF_IMM_W, `T_RETF_IMM_B);
            `OP_JCNTZ: begin
               is_cond = 1'b1;
               t_tk = {8'h00, `T_JCNTZ_TK};
               t_nt = {8'h00, `T_JCNTZ_NT};
            end
            `OP_LOOP, `OP_LOOP_Z, `OP_LOOP_NZ: begin
               is_cond = 1'b1;
               t_tk = {8'h00, `T_LOOP_TK};
               t_nt = {8'h00, `T_LOOP_NT};
            end
            `OP_ENTER: t_tk = enter_clk;
            `OP_LEAVE: t_tk = {8'h00, `T_LEAVE};
            `OP_INT_TYPE: t_tk = {8'h00, `T_INT_TYPE};
            `OP_INT_BRK: t_tk = {8'h00, `T_INT_BRK};
            `OP_OVTRAP: begin
               is_cond = 1'b1;
               t_tk = {8'h00, `T_OVTRAP_TK};
               t_nt = {8'h00, `T_OVTRAP_NT};
            end
            `OP_TRAP_RTN: t_tk = {8'h00, `T_TRAP_RTN};
            `OP_BOUND: begin
               t_tk = {8'h00, `T_BOUND_MIN};
               t_max = {8'h00, `T_BOUND_MAX};
            end
            `OP_GRP_FF: begin
               // reg field of the mod-reg-r/m byte picks the form;
               // mod 11 means a register operand, no memory fetch
               case (b1_now[5:3])
                  3'h2: t_tk = (b1_now[7:6] == `MOD_REG) ?
                     bw(`T_CALL_IND_REG_W, `T_CALL_IND_REG_B) :
                     bw(`T_CALL_IND_MEM_W, `T_CALL_IND_MEM_B);
                  3'h3: t_tk = bw(`T_CALL_FIND_W, `T_CALL_FIND_B);
                  3'h4: t_tk = (b1_now[7:6] == `MOD_REG) ? {8'h00, `T_JUMP_IND_REG} :
                     bw(`T_JUMP_IND_MEM_W, `T_JUMP_IND_MEM_B);
                  3'h5: t_tk = bw(`T_JUMP_FIND_W, `T_JUMP_FIND_B);
                  default: known = 1'b0;
               endcase
            end
            default: known = 1'b0;
         endcase
      end
      // only the repeated string output of word operands adds transfers on the byte bus, one per repetition;
      // every other count already holds its word transfers
      if (BYTE_BUS != 0 && word_op_i && rep_q && op_now[7:1] == `OP_STR_OUT_PAT)
         t_tk = t_tk + {8'h00, `T_WORD_XFER} * rep_count_i;
      if (t_max == 16'h0000)
         t_max = t_tk;
      if (!is_cond)
         t_nt = t_tk;
   end

   // registered decode results, updated once per completed instruction
   always @(posedge clock_i) begin
      if (srst_i) begin
         state_q <= S_OP;
         rep_q <= 1'b0;
         op_q <= 8'h00;
         b1_q <= 8'h00;
         b2_q <= 8'h00;
         decode_valid_o <= 1'b0;
         known_o <= 1'b0;
         opcode_o <= 8'h00;
         rep_o <= 1'b0;
         layout_o <= `LAY_NONE;
         mod_o <= 2'h0;
         rm_o <= 3'h0;
         reg_operand_o <= 1'b0;
         operand_o <= 16'h0000;
         level_o <= 8'h00;
         conditional_o <= 1'b0;
         cond_true_o <= 1'b0;
         clocks_taken_o <= {CNT_W{1'b0}};
         clocks_not_taken_o <= {CNT_W{1'b0}};
         clocks_o <= {CNT_W{1'b0}};
         clocks_max_o <= {CNT_W{1'b0}};
      end else begin
         state_q <= state_d;
         decode_valid_o <= done;
         if (byte_valid_i && state_q == S_OP) begin
            if (byte_i == `OP_REP_PREFIX)
               rep_q <= 1'b1; // prefix held until its instruction ends
            op_q <= byte_i;
         end
         if (byte_valid_i && state_q == S_B1)
            b1_q <= byte_i;
         if (byte_valid_i && state_q == S_B2)
            b2_q <= byte_i;
         if (done) begin
            rep_q <= 1'b0;
            known_o <= known;
            opcode_o <= op_now;
            rep_o <= rep_q;
            layout_o <= lay;
            mod_o <= (lay == `LAY_MODRM) ? b1_now[7:6] : 2'h0;
            rm_o <= (lay == `LAY_MODRM) ? b1_now[2:0] : 3'h0;
            reg_operand_o <= (lay == `LAY_MODRM) && (b1_now[7:6] == `MOD_REG);
            // low byte first, then high byte
            operand_o <= (need >= 2'h2) ? {b2_now, b1_now} :
               ((need == 2'h1) ? {8'h00, b1_now} : 16'h0000);
            level_o <= (lay == `LAY_ENTER) ? b3_now : 8'h00;
            conditional_o <= is_cond;
            cond_true_o <= is_jcc ? jcc_true : cond_taken_i;
            clocks_taken_o <= t_tk[CNT_W-1:0];
            clocks_not_taken_o <= t_nt[CNT_W-1:0];
            // the core's verdict picks the spent count; the flag test is
            // only a hint for the short jumps
            clocks_o <= (is_cond && !cond_taken_i) ? t_nt[CNT_W-1:0] :
               t_tk[CNT_W-1:0];
            clocks_max_o <= t_max[CNT_W-1:0];
         end
      end
   end
endmodule // ctl_xfer_decode

// ==== test/ctl_xfer_props.sv ====
// assertion checker for the control-transfer decode and timing block
`timescale 1ns/1ps
`include "ctl_xfer_map.vh"
module ctl_xfer_props #(
   parameter BYTE_BUS = 0,
   parameter CNT_W = 16
) (
   input wire clock_i,
   input wire srst_i,
   input wire byte_valid_i,
   input wire decode_valid_o,
   input wire known_o,
   input wire [7:0] opcode_o,
   input wire [2:0] layout_o,
   input wire [1:0] mod_o,
   input wire reg_operand_o,
   input wire conditional_o,
   input wire cond_true_o,
   input wire [CNT_W-1:0] clocks_taken_o,
   input wire [CNT_W-1:0] clocks_not_taken_o,
   input wire [CNT_W-1:0] clocks_o,
   input wire [CNT_W-1:0] clocks_max_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);
   // a decode that the block recognised
   wire dk = decode_valid_o && known_o;

   AST_VALID_CAUSE: assert property (decode_valid_o |-> $past(byte_valid_i))
      else $error("decode reported without a byte taken");
   AST_RESET_CLEAR: assert property ($fell(srst_i) |-> !decode_valid_o && clocks_o == 0)
      else $error("outputs not cleared by reset");
   AST_OUTPUTS_HOLD: assert property (!decode_valid_o && !$past(srst_i) |-> $stable(clocks_o))
      else $error("clock count changed between decodes");
   AST_UNCOND_SAME: assert property (dk && !conditional_o |-> clocks_taken_o == clocks_not_taken_o)
      else $error("unconditional counts differ");
   AST_JCC_TIMES: assert property (dk && opcode_o[7:4] == `OP_JCC_HI |->
      conditional_o && clocks_taken_o == 13 && clocks_not_taken_o == 4)
      else $error("conditional jump counts wrong");
   AST_COUNTZ_TIMES: assert property (dk && opcode_o == `OP_JCNTZ |->
      clocks_taken_o == 15 && clocks_not_taken_o == 5)
      else $error("count-zero jump counts wrong");
   AST_LOOP_TIMES: assert property (dk && opcode_o[7:2] == 6'h38 && opcode_o[1:0] != 2'h3 |->
      clocks_taken_o == 16 && clocks_not_taken_o == 6)
      else $error("loop counts wrong");
   AST_LOOP_SELECT: assert property (dk && opcode_o[7:2] == 6'h38 |->
      clocks_o == (cond_true_o ? clocks_taken_o : clocks_not_taken_o))
      else $error("selected count does not follow condition");
   AST_CALL_NEAR: assert property (dk && opcode_o == `OP_CALL_NEAR |->
      clocks_o == (BYTE_BUS ? 19 : 15) && layout_o == `LAY_DISP16)
      else $error("near call decode wrong");
   AST_FRAME_EXIT: assert property (dk && opcode_o == `OP_LEAVE |->
      clocks_o == 8 && layout_o == `LAY_NONE)
      else $error("frame exit decode wrong");
   AST_BOUND_SPAN: assert property (dk && opcode_o == `OP_BOUND |->
      clocks_o >= 33 && clocks_max_o == 35)
      else $error("bounds check span wrong");
   AST_REG_OPERAND: assert property (dk && layout_o == `LAY_MODRM |->
      reg_operand_o == (mod_o == `MOD_REG))
      else $error("register operand flag wrong");

   // main scenarios reached
   C_CALL: cover property (dk && opcode_o == `OP_CALL_NEAR);
   C_LOOP_TAKEN: cover property (dk && opcode_o == `OP_LOOP && cond_true_o);
   C_BOUND_REG: cover property (dk && opcode_o == `OP_BOUND && reg_operand_o);
endmodule // ctl_xfer_props

bind ctl_xfer_decode ctl_xfer_props #(.BYTE_BUS(BYTE_BUS), .CNT_W(CNT_W)) u_props (
   .clock_i(clock_i), .srst_i(srst_i), .byte_valid_i(byte_valid_i),
   .decode_valid_o(decode_valid_o), .known_o(known_o), .opcode_o(opcode_o),
   .layout_o(layout_o), .mod_o(mod_o), .reg_operand_o(reg_operand_o),
   .conditional_o(conditional_o), .cond_true_o(cond_true_o),
   .clocks_taken_o(clocks_taken_o), .clocks_not_taken_o(clocks_not_taken_o),
   .clocks_o(clocks_o), .clocks_max_o(clocks_max_o));

// ==== test/fetch_model.sv ====
// fetch-side model that feeds instruction bytes to the decoder
`timescale 1ns/1ps
module fetch_model (
   input wire clock_i,
   input wire go_i,
   input wire slow_i,
   input wire [2:0] count_i,
   input wire [31:0] bytes_i,
   output reg byte_valid_o,
   output reg [7:0] byte_o
);
   reg [31:0] sh;
   reg [2:0] left;
   reg idle;
   initial begin
      byte_valid_o = 1'b0;
      byte_o = 8'hA5;
      left = 3'h0;
      idle = 1'b0;
   end
   // bytes change on the falling edge; slow mode leaves a gap between bytes
   always @(negedge clock_i) begin
      if (left == 3'h0 && go_i) begin
         sh = bytes_i;
         left = count_i;
         idle = 1'b0;
      end
      if (left != 3'h0 && !idle) begin // bytes are already queued
         byte_valid_o <= 1'b1;
         byte_o <= sh[7:0];
         sh = sh >> 8;
         left = left - 3'h1;
         idle = slow_i;
      end else begin
         // idle lane toggles so a stale byte is never mistaken for data
         byte_valid_o <= 1'b0;
         byte_o <= ~byte_o;
         idle = 1'b0;
      end
   end
endmodule // fetch_model

// ==== test/test_ctl_xfer_decode.sv ====
// self-checking testbench for the control-transfer decoder
`timescale 1ns/1ps
module test_ctl_xfer_decode;
   reg clock_i = 1'b0;
   reg srst_i = 1'b1;
   reg cond_taken_i = 1'b0;
   reg [4:0] flags_i = 5'h00;
   reg [15:0] rep_count_i = 16'h0000;
   reg word_op_i = 1'b0;
   reg go = 1'b0;
   reg slow = 1'b0;
   reg [2:0] cnt = 3'h0;
   reg [31:0] bytes = 32'h0;
   wire byte_valid_i, decode_valid_o, known_o, rep_o, reg_operand_o, conditional_o;
   wire cond_true_o;
   wire [7:0] byte_i, opcode_o, level_o;
   wire [2:0] layout_o, rm_o;
   wire [1:0] mod_o;
   wire [15:0] operand_o, clocks_taken_o, clocks_not_taken_o, clocks_o, clocks_max_o;
   integer n_mismatch = 0;
   integer n_checks = 0;
   integer i;
   integer j;

   always #20 clock_i = ~clock_i;

   fetch_model u_fetch (.clock_i(clock_i), .go_i(go), .slow_i(slow), .count_i(cnt),
      .bytes_i(bytes), .byte_valid_o(byte_valid_i), .byte_o(byte_i));

   ctl_xfer_decode u_dut (.clock_i(clock_i), .srst_i(srst_i), .byte_valid_i(byte_valid_i),
      .byte_i(byte_i), .cond_taken_i(cond_taken_i), .flags_i(flags_i),
      .rep_count_i(rep_count_i), .word_op_i(word_op_i), .decode_valid_o(decode_valid_o),
      .known_o(known_o), .opcode_o(opcode_o), .rep_o(rep_o), .layout_o(layout_o),
      .mod_o(mod_o), .rm_o(rm_o), .reg_operand_o(reg_operand_o), .operand_o(operand_o),
      .level_o(level_o), .conditional_o(conditional_o), .cond_true_o(cond_true_o),
      .clocks_taken_o(clocks_taken_o), .clocks_not_taken_o(clocks_not_taken_o),
      .clocks_o(clocks_o), .clocks_max_o(clocks_max_o));

   task summarize;
      begin
         $display("checks %0d mismatches %0d", n_checks, n_mismatch);
         if (n_mismatch == 0 && n_checks > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask

   task chk(input string what, input [15:0] seen, input [15:0] exp);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
         end
      end
   endtask

   // hand bytes to the fetch model, alternating prompt and gapped delivery
   task op(input [31:0] b, input [2:0] n, input [15:0] tk, input [15:0] nt);
      integer k;
      begin
         @(negedge clock_i);
         bytes <= b;
         cnt <= n;
         slow <= ~slow;
         go <= 1'b1;
         @(negedge clock_i);
         go <= 1'b0;
         k = 0;
         while (decode_valid_o !== 1'b1 && k < 30) begin
            @(negedge clock_i);
            k = k + 1;
         end
         if (decode_valid_o !== 1'b1) begin
            n_mismatch = n_mismatch + 1;
            $display("CHECK FAILED decode_valid_o expected 1 seen 0");
            summarize;
         end
         chk("known_o", {15'h0, known_o}, 16'h0001);
         chk("clocks_taken_o", clocks_taken_o, tk);
         chk("clocks_not_taken_o", clocks_not_taken_o, nt);
      end
   endtask

   // reference branch condition, flags are {o,s,z,c,p}
   function cc(input [3:0] c, input [4:0] f);
      reg r;
      begin
         case (c[3:1])
            3'h0: r = f[4];
            3'h1: r = f[1];
            3'h2: r = f[2];
            3'h3: r = f[1] | f[2];
            3'h4: r = f[3];
            3'h5: r = f[0];
            3'h6: r = f[3] ^ f[4];
            default: r = (f[3] ^ f[4]) | f[2];
         endcase
         cc = r ^ c[0];
      end
   endfunction

   task t_reset;
      begin
         chk("clocks_o", clocks_o, 16'h0000);
         op(32'h0000_00C3, 3'h1, 16'h0010, 16'h0010);
         @(negedge clock_i);
         srst_i <= 1'b1;
         repeat (3) @(negedge clock_i);
         srst_i <= 1'b0;
         chk("known_o", {15'h0, known_o}, 16'h0000);
         chk("clocks_o", clocks_o, 16'h0000);
         $display("test reset done");
      end
   endtask

   task t_call_jump;
      begin
         op(32'h0012_34E8, 3'h3, 16'h000F, 16'h000F);
         chk("operand_o", operand_o, 16'h1234);
         chk("layout_o", {13'h0, layout_o}, 16'h0002);
         chk("opcode_o", {8'h0, opcode_o}, 16'h00E8);
         chk("conditional_o", {15'h0, conditional_o}, 16'h0000);
         op(32'h0000_D2FF, 3'h2, 16'h000D, 16'h000D);
         chk("reg_operand_o", {15'h0, reg_operand_o}, 16'h0001);
         chk("mod_o", {14'h0, mod_o}, 16'h0003);
         op(32'h0000_17FF, 3'h2, 16'h0013, 16'h0013);
         op(32'h0000_E0FF, 3'h2, 16'h000B, 16'h000B);
         op(32'h0000_27FF, 3'h2, 16'h0011, 16'h0011);
         op(32'h0000_85EB, 3'h2, 16'h000E, 16'h000E);
         chk("operand_o", operand_o, 16'h0085);
         op(32'h00FF_01E9, 3'h3, 16'h000E, 16'h000E);
         op(32'h0000_00C3, 3'h1, 16'h0010, 16'h0010);
         op(32'h0000_10C2, 3'h3, 16'h0012, 16'h0012);
         chk("operand_o", operand_o, 16'h0010);
         op(32'h0002_00CA, 3'h3, 16'h0019, 16'h0019);
         $display("test calls jumps returns done");
      end
   endtask

   task t_cond_jumps;
      reg [4:0] fl [0:2];
      reg e;
      begin
         fl[0] = 5'h00;
         fl[1] = 5'h1F;
         fl[2] = 5'h10;
         for (j = 0; j < 3; j = j + 1) begin
            for (i = 0; i < 16; i = i + 1) begin
               e = cc(i[3:0], fl[j]);
               flags_i <= fl[j];
               cond_taken_i <= e;
               op({16'h0, 8'hF0, 4'h7, i[3:0]}, 3'h2, 16'h000D, 16'h0004);
               chk("cond_true_o", {15'h0, cond_true_o}, {15'h0, e});
               chk("clocks_o", clocks_o, e ? 16'h000D : 16'h0004);
            end
         end
         $display("test conditional jumps done");
      end
   endtask

   task t_loops;
      reg [7:0] opc [0:3];
      reg [15:0] ex;
      begin
         opc[0] = 8'hE3;
         opc[1] = 8'hE2;
         opc[2] = 8'hE1;
         opc[3] = 8'hE0;
         for (i = 0; i < 8; i = i + 1) begin
            cond_taken_i <= i[0];
            if (i < 2)
               op({16'h0, 8'hFC, opc[0]}, 3'h2, 16'h000F, 16'h0005);
            else
               op({16'h0, 8'hFC, opc[i/2]}, 3'h2, 16'h0010, 16'h0006);
            ex = (i < 2) ? (i[0] ? 16'h000F : 16'h0005) : (i[0] ? 16'h0010 : 16'h0006);
            chk("clocks_o", clocks_o, ex);
            chk("cond_true_o", {15'h0, cond_true_o}, {15'h0, i[0]});
            chk("conditional_o", {15'h0, conditional_o}, 16'h0001);
         end
         $display("test loops done");
      end
   endtask

   task t_frames_traps;
      begin
         op(32'h0001_00C8, 3'h4, 16'h000F, 16'h000F);
         op(32'h0101_00C8, 3'h4, 16'h0019, 16'h0019);
         op(32'h0301_00C8, 3'h4, 16'h0036, 16'h0036);
         chk("level_o", {8'h0, level_o}, 16'h0003);
         op(32'h0000_00C9, 3'h1, 16'h0008, 16'h0008);
         op(32'h0000_21CD, 3'h2, 16'h002F, 16'h002F);
         op(32'h0000_00CC, 3'h1, 16'h002D, 16'h002D);
         cond_taken_i <= 1'b1;
         op(32'h0000_00CE, 3'h1, 16'h0030, 16'h0004);
         chk("clocks_o", clocks_o, 16'h0030);
         cond_taken_i <= 1'b0;
         op(32'h0000_00CE, 3'h1, 16'h0030, 16'h0004);
         chk("clocks_o", clocks_o, 16'h0004);
         op(32'h0000_00CF, 3'h1, 16'h001C, 16'h001C);
         $display("test frames traps done");
      end
   endtask

   task t_bound_rep;
      begin
         word_op_i <= 1'b1;
         op(32'h0000_C162, 3'h2, 16'h0021, 16'h0021);
         chk("reg_operand_o", {15'h0, reg_operand_o}, 16'h0001);
         chk("clocks_max_o", clocks_max_o, 16'h0023);
         op(32'h0000_0762, 3'h2, 16'h0021, 16'h0021);
         chk("reg_operand_o", {15'h0, reg_operand_o}, 16'h0000);
         chk("rm_o", {13'h0, rm_o}, 16'h0007);
         word_op_i <= 1'b0;
         rep_count_i <= 16'h0003;
         op(32'h0000_6FF2, 3'h2, 16'h0020, 16'h0020);
         chk("rep_o", {15'h0, rep_o}, 16'h0001);
         chk("opcode_o", {8'h0, opcode_o}, 16'h006F);
         rep_count_i <= 16'h0000;
         op(32'h0000_6FF2, 3'h2, 16'h0008, 16'h0008);
         $display("test bounds and repeat done");
      end
   endtask

   // cut a hang short
   initial begin
      #800000;
      n_mismatch = n_mismatch + 1;
      summarize;
   end

   initial begin
      repeat (16) @(negedge clock_i);
      srst_i <= 1'b0;
      t_reset;
      t_call_jump;
      t_cond_jumps;
      t_loops;
      t_frames_traps;
      t_bound_rep;
      repeat (2) @(negedge clock_i);
      summarize;
   end
endmodule // test_ctl_xfer_decode
